// file: design/hold_timer.sv
`timescale 1ns/1ns
module hold_timer #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic [W-1:0] count_o
);
  logic [W-1:0] count_reg;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_reg <= '0;
    else if (load_i)
      count_reg <= value_i;
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end
  assign count_o = count_reg;
endmodule : hold_timer

// file: design/special_register_transfer_unit.sv
`timescale 1ns/1ns
module special_register_transfer_unit (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic half_rate_i,
  input wire logic monitor_mode_i,
  input wire logic issue_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [63:0] scalar_src_i,
  input wire logic si_reserved_i,
  input wire logic shared_conflict_i,
  input wire logic shared_buf_full_i,
  input wire logic vq_full_i,
  input wire logic global_pending_i,
  input wire logic blk036_busy_i,
  input wire logic [6:0] blk036_len_i,
  input wire logic t_target_written_i,
  input wire logic blk037_busy_i,
  input wire logic clock_load_i,
  input wire logic [63:0] clock_load_val_i,
  input wire logic [6:0] vector_length_i,
  input wire logic mask_set_146_i,
  input wire logic mask_set_175_i,
  input wire logic mask_set_003_i,
  input wire logic elem_read_issued_i,
  input wire logic [31:0] mask_bus_i,
  input wire logic [31:0] perf_status_i,
  input wire logic maint_set_i,
  input wire logic [7:0] maint_bits_i,
  input wire logic [5:0] cluster_index_i,
  input wire logic [4:0] cpu_index_i,
  input wire logic program_state_i,
  input wire logic uncorrected_mem_err_i,
  input wire logic corrected_mem_err_i,
  input wire logic float_err_flag_i,
  input wire logic float_irq_en_i,
  input wire logic range_irq_en_i,
  input wire logic bidir_mem_en_i,
  output logic issue_hold_o,
  output logic issued_o,
  output logic mask_half_sel_o,
  output logic result_valid_o,
  output logic [2:0] result_dest_o,
  output logic [63:0] result_o,
  output logic tas_ok_o,
  output logic [7:0] maint_modes_o,
  output logic [31:0] semaphore_bits_o
);
  typedef enum logic [3:0] {
    VM_IDLE = 4'h1,
    VM_WAIT = 4'h2,
    VM_LO = 4'h4,
    VM_HI = 4'h8
  } vm_state_t;

  logic [6:0] op_w;
  logic [5:0] jk_w;
  logic [2:0] i_w;
  logic [2:0] j_w;
  logic [2:0] k_w;
  logic rd_clock, rd_sem, rd_shared, rd_mask, rd_status;
  logic perf_rd, perf_up, maint_clr, perf_lo, wr_sem, wr_shared, rd_t, wr_t;
  logic ours_w, shared_op, perf_op, local_op, align_op, hold_w, issue_w;
  logic cl_zero, busy_res, t_hold, mask_busy_w;
  logic [63:0] clock_w;
  logic [63:0] status_w;
  logic [31:0] perf_stat_w;
  logic [4:0] res_cnt;
  logic [4:0] res_load_val;
  logic res_load;
  logic [4:0] tas_cnt;
  logic [7:0] mask_cnt;
  logic [7:0] mask_load_val;
  logic [7:0] elem_cnt;
  logic phase_reg;
  logic [31:0] semaphore_bits_reg;
  logic [63:0] shared_reg_j [0:7];
  logic [63:0] t_reg [0:63];
  logic [srt_pkg::PERF_W-1:0] perf_reg [0:3];
  logic [1:0] perf_cnt_reg;
  logic [1:0] perf_slice_reg;
  logic [7:0] maint_reg;
  logic t_wr_prev_reg;
  vm_state_t vm_reg;
  logic [63:0] res_val_reg;
  logic [63:0] res_val_next;
  logic [2:0] dest_reg;
  logic [63:0] result_reg;
  logic result_valid_reg;

  assign op_w = instr_i[srt_pkg::OP_MSB:srt_pkg::OP_LSB];
  assign i_w = instr_i[srt_pkg::I_MSB:srt_pkg::I_LSB];
  assign j_w = instr_i[srt_pkg::J_MSB:srt_pkg::J_LSB];
  assign k_w = instr_i[srt_pkg::K_MSB:srt_pkg::K_LSB];
  assign jk_w = {j_w, k_w};
  assign rd_clock = op_w == srt_pkg::OP_RD_SPECIAL && jk_w == srt_pkg::JK_CLOCK;
  assign rd_sem = op_w == srt_pkg::OP_RD_SPECIAL && jk_w == srt_pkg::JK_SEM;
  assign rd_shared = op_w == srt_pkg::OP_RD_SPECIAL && k_w == srt_pkg::K_SHARED;
  assign rd_mask = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_MASK;
  assign rd_status = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_STATUS;
  assign perf_rd = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_PERF_RD;
  assign perf_up = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_PERF_UP;
  assign maint_clr = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_MAINT_CLR;
  assign perf_lo = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_PERF_LO;
  assign wr_sem = op_w == srt_pkg::OP_WR_SPECIAL && jk_w == srt_pkg::JK_SEM;
  assign wr_shared = op_w == srt_pkg::OP_WR_SPECIAL && k_w == srt_pkg::K_SHARED;
  assign rd_t = op_w == srt_pkg::OP_T_READ;
  assign wr_t = op_w == srt_pkg::OP_T_WRITE;
  assign shared_op = rd_sem | rd_shared | wr_sem | wr_shared;
  assign perf_op = perf_rd | perf_up | maint_clr | perf_lo;
  assign local_op = rd_clock | rd_status | perf_op | rd_t | wr_t;
  assign align_op = rd_mask | wr_sem | wr_shared;
  assign ours_w = shared_op | local_op | rd_mask;
  assign cl_zero = cluster_index_i == '0;

  // one result slot; a new result waits until the previous one is out
  assign busy_res = res_cnt != '0 || vm_reg != VM_IDLE;
  assign t_hold = blk037_busy_i || (!half_rate_i && blk036_busy_i)
    || (half_rate_i && blk036_busy_i && (blk036_len_i > srt_pkg::BLK_LEN_LIMIT
    || !t_target_written_i));

  always_comb
  begin
    hold_w = busy_res;
    if (si_reserved_i)
      hold_w = 1'b1;
    if (shared_op && (shared_conflict_i || shared_buf_full_i))
      hold_w = 1'b1;
    if (rd_mask && vq_full_i)
      hold_w = 1'b1;
    if (rd_t && t_wr_prev_reg)
      hold_w = 1'b1;
    if ((rd_t || wr_t) && t_hold)
      hold_w = 1'b1;
    if (half_rate_i && align_op && !phase_reg)
      hold_w = 1'b1;
    if (local_op && global_pending_i)
      hold_w = 1'b1;
  end

  assign issue_hold_o = issue_valid_i && ours_w && hold_w;
  assign issue_w = issue_valid_i && ours_w && !hold_w;
  assign issued_o = issue_w;

  // system clock phase; high on the cycle that closes a system period
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      phase_reg <= 1'b0;
    else
      phase_reg <= half_rate_i ? !phase_reg : 1'b0;
  end

  wall_counter u_clock (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .step_i(!half_rate_i || phase_reg),
    .load_i(clock_load_i && monitor_mode_i),
    .value_i(clock_load_val_i),
    .count_o(clock_w)
  );

  always_comb
  begin
    status_w = 64'h0000_0000_ffff_ffff;
    status_w[srt_pkg::SW_GROUPED] = !cl_zero;
    status_w[srt_pkg::SW_PSTATE] = program_state_i;
    status_w[srt_pkg::SW_UME] = uncorrected_mem_err_i;
    status_w[srt_pkg::SW_CME] = corrected_mem_err_i;
    status_w[srt_pkg::SW_FPE] = float_err_flag_i;
    status_w[srt_pkg::SW_FIRQ] = float_irq_en_i;
    status_w[srt_pkg::SW_RIRQ] = range_irq_en_i;
    status_w[srt_pkg::SW_BIDIR] = bidir_mem_en_i;
    if (monitor_mode_i)
    begin
      status_w[srt_pkg::SW_CPU_LSB +: 5] = cpu_index_i;
      status_w[srt_pkg::SW_CL_LSB +: 6] = cluster_index_i;
    end
  end

  assign perf_stat_w = monitor_mode_i ? perf_status_i : 32'h0;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      semaphore_bits_reg <= '0;
    else if (issue_w && wr_sem && !cl_zero)
      semaphore_bits_reg <= scalar_src_i[srt_pkg::SEM_LSB +: 32];
  end
  assign semaphore_bits_o = semaphore_bits_reg;

  // storage arrays carry no reset; software loads them before use
  always_ff @(posedge clk_i)
  begin
    if (issue_w && wr_shared && !cl_zero)
      shared_reg_j[j_w] <= scalar_src_i;
    if (issue_w && wr_t)
      t_reg[jk_w] <= scalar_src_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      t_wr_prev_reg <= 1'b0;
    else
      t_wr_prev_reg <= issue_w && wr_t;
  end

  // pointer = counter index and 16-bit slice; privileged ops are no-ops outside monitor
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      perf_cnt_reg <= '0;
      perf_slice_reg <= '0;
      for (int n = 0; n < 4; n++)
        perf_reg[n] <= '0;
    end
    else if (issue_w && monitor_mode_i)
    begin
      if (perf_rd)
      begin
        if (perf_slice_reg == srt_pkg::PERF_SLICES - 2'h1)
        begin
          perf_slice_reg <= '0;
          perf_cnt_reg <= perf_cnt_reg + 2'h1;
        end
        else
          perf_slice_reg <= perf_slice_reg + 2'h1;
      end
      else if (perf_up)
      begin
        perf_reg[perf_cnt_reg] <= perf_reg[perf_cnt_reg]
          + (srt_pkg::PERF_W'(1) << srt_pkg::PERF_UP_BIT_A)
          + (srt_pkg::PERF_W'(1) << srt_pkg::PERF_UP_BIT_B);
        perf_cnt_reg <= perf_cnt_reg + 2'h1;
        perf_slice_reg <= '0;
      end
      else if (maint_clr)
      begin
        perf_cnt_reg <= '0;
        perf_slice_reg <= '0;
      end
      else if (perf_lo)
        perf_reg[perf_cnt_reg][15:0] <= perf_reg[perf_cnt_reg][15:0] + 16'h1;
    end
  end

  // modes drop at once, well inside the allowed stop time
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      maint_reg <= '0;
    else if (issue_w && maint_clr && monitor_mode_i)
      maint_reg <= '0;
    else if (maint_set_i && monitor_mode_i)
      maint_reg <= maint_reg | maint_bits_i;
  end
  assign maint_modes_o = maint_reg;

  always_comb
  begin
    mask_load_val = srt_pkg::MASK_BUSY_003;
    if (mask_set_146_i)
      mask_load_val = 8'(vector_length_i) + srt_pkg::MASK_BUSY_SET;
    else if (mask_set_175_i)
      mask_load_val = 8'(vector_length_i) + srt_pkg::MASK_BUSY_175;
  end

  hold_timer #(.W(8)) u_mask_busy (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(mask_set_146_i || mask_set_175_i || mask_set_003_i),
    .value_i(mask_load_val),
    .count_o(mask_cnt)
  );

  hold_timer #(.W(8)) u_elem_delay (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(elem_read_issued_i),
    .value_i(srt_pkg::ELEM_RD_DELAY),
    .count_o(elem_cnt)
  );

  assign mask_busy_w = mask_cnt != '0 || elem_cnt != '0;

  hold_timer #(.W(5)) u_tas (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(issue_w && wr_sem),
    .value_i(srt_pkg::SEM_TAS_WAIT),
    .count_o(tas_cnt)
  );
  assign tas_ok_o = tas_cnt <= 5'h1;

  // vector-stage issue of a mask read is leaving VM_WAIT
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      vm_reg <= VM_IDLE;
    else
    begin
      case (vm_reg)
        VM_IDLE:
          if (issue_w && rd_mask)
            vm_reg <= VM_WAIT;
        VM_WAIT:
          if (!mask_busy_w && !(mask_set_146_i || mask_set_175_i || mask_set_003_i))
            vm_reg <= VM_LO;
        VM_LO:
          vm_reg <= VM_HI;
        VM_HI:
          vm_reg <= VM_IDLE;
        default:
          vm_reg <= VM_IDLE;
      endcase
    end
  end
  assign mask_half_sel_o = vm_reg == VM_HI;

  always_comb
  begin
    res_load = 1'b0;
    res_load_val = srt_pkg::LAT_ONE;
    res_val_next = 64'h0;
    if (issue_w)
    begin
      res_load = !rd_mask && !wr_sem && !wr_shared && !wr_t;
      if (rd_clock)
        res_val_next = clock_w;
      else if (rd_sem || rd_shared)
      begin
        res_load_val = srt_pkg::LAT_SHARED;
        if (!cl_zero && rd_sem)
          res_val_next = {semaphore_bits_reg, 32'h0};
        else if (!cl_zero)
          res_val_next = shared_reg_j[j_w];
      end
      else if (rd_status)
        res_val_next = status_w;
      else if (perf_rd && monitor_mode_i)
        res_val_next = {perf_stat_w[15:0],
          perf_reg[perf_cnt_reg][perf_slice_reg * srt_pkg::PERF_SLICE_W +: 16], 32'h0};
      else if (perf_up || maint_clr || perf_lo)
        res_val_next = {perf_stat_w, 32'h0};
      else if (rd_t)
        res_val_next = t_reg[jk_w];
    end
    else if (vm_reg == VM_WAIT && !mask_busy_w
      && !(mask_set_146_i || mask_set_175_i || mask_set_003_i))
    begin
      res_load = 1'b1;
      res_load_val = srt_pkg::LAT_MASK;
    end
  end

  hold_timer #(.W(5)) u_result (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(res_load),
    .value_i(res_load_val),
    .count_o(res_cnt)
  );

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      res_val_reg <= '0;
      dest_reg <= '0;
    end
    else if (issue_w)
    begin
      res_val_reg <= res_val_next;
      dest_reg <= i_w;
    end
    else if (vm_reg == VM_LO)
      res_val_reg[srt_pkg::HALF-1:0] <= mask_bus_i;
    else if (vm_reg == VM_HI)
      res_val_reg[63:srt_pkg::HALF] <= mask_bus_i;
  end

  // fire on the cycle before the due cycle so the output is a flop
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_valid_reg <= 1'b0;
      result_reg <= '0;
    end
    else if (res_load && res_load_val == srt_pkg::LAT_ONE)
    begin
      result_valid_reg <= 1'b1;
      result_reg <= res_val_next;
    end
    else if (res_cnt == srt_pkg::CNT_FIRE && !res_load)
    begin
      result_valid_reg <= 1'b1;
      result_reg <= res_val_reg;
    end
    else
      result_valid_reg <= 1'b0;
  end
  assign result_valid_o = result_valid_reg;
  assign result_o = result_reg;
  assign result_dest_o = dest_reg;

  sequence s_sem_wr;
    issue_w && wr_sem;
  endsequence
  sequence s_shared_rd;
    issue_w && (rd_sem || rd_shared);
  endsequence

  property p_clock_step;
    @(posedge clk_i) disable iff (!resetn_i)
    !half_rate_i && !clock_load_i |=> clock_w == $past(clock_w) + 64'h1;
  endproperty
  a_clock_step: assert property (p_clock_step) else $error("wall count missed a step");

  property p_clock_half;
    @(posedge clk_i) disable iff (!resetn_i)
    half_rate_i && !phase_reg && !clock_load_i |=> $stable(clock_w);
  endproperty
  a_clock_half: assert property (p_clock_half) else $error("wall count off system rate");

  property p_sem_write;
    @(posedge clk_i) disable iff (!resetn_i)
    s_sem_wr and !cl_zero |=> semaphore_bits_reg == $past(scalar_src_i[63:32]);
  endproperty
  a_sem_write: assert property (p_sem_write) else $error("semaphore load wrong");

  property p_sem_cl0;
    @(posedge clk_i) disable iff (!resetn_i)
    s_sem_wr and cl_zero |=> $stable(semaphore_bits_reg);
  endproperty
  a_sem_cl0: assert property (p_sem_cl0) else $error("semaphore written with cluster 0");

  property p_mask_halves;
    @(posedge clk_i) disable iff (!resetn_i)
    vm_reg == VM_LO |=> mask_half_sel_o ##1 !mask_half_sel_o ##1 result_valid_o;
  endproperty
  a_mask_halves: assert property (p_mask_halves) else $error("mask halves out of step");

  property p_maint_clr;
    @(posedge clk_i) disable iff (!resetn_i)
    issue_w && maint_clr && monitor_mode_i |=> maint_reg == '0 && perf_cnt_reg == '0;
  endproperty
  a_maint_clr: assert property (p_maint_clr) else $error("maintenance not cleared");

  property p_reserved;
    @(posedge clk_i) disable iff (!resetn_i)
    issue_valid_i && ours_w && si_reserved_i |-> issue_hold_o && !issued_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("issued on reserved register");

  property p_t_after_write;
    @(posedge clk_i) disable iff (!resetn_i)
    issue_w && wr_t ##1 issue_valid_i && rd_t |-> !issued_o;
  endproperty
  a_t_after_write: assert property (p_t_after_write) else $error("T read after write");

  property p_shared_lat;
    @(posedge clk_i) disable iff (!resetn_i)
    s_shared_rd |=> !result_valid_o [*8] ##7 result_valid_o;
  endproperty
  a_shared_lat: assert property (p_shared_lat) else $error("shared read latency wrong");

  property p_tas;
    @(posedge clk_i) disable iff (!resetn_i)
    s_sem_wr |=> !tas_ok_o ##10 tas_ok_o;
  endproperty
  a_tas: assert property (p_tas) else $error("test-and-set spacing wrong");
endmodule : special_register_transfer_unit

// file: design/srt_pkg.sv
// Operation
// - 64-bit wall counter steps by one each clock; read by 072i00; monitor-only load.
// - half-rate variant steps the wall counter at system clock rate.
// - semaphores read left-justified, written from upper source half, top semaphore is sign.
// - cluster index zero: semaphore/shared reads give zero, writes do nothing.
// - shared read copies selected shared register; shared write loads it from source.
// - vector mask read returns all 64 bits over two 32-bit halves.
// - counter read: 16 counter bits at 32-47, 16 status at 48-63, pointer advances.
// - upper increment test adds at bits 22 and 38, returns status, next counter.
// - clear-maintenance clears all modes and pointer, returns status in 32-63.
// - lower increment adds one at bit 0, no carry past bit 15, returns status.
// - status read sets low 32 bits to ones, status bits in the upper half.
// - status layout: 63,57,53..48 flags, 44-40 cpu index, 37-32 cluster index.
// - status read outside monitor mode zeroes cpu and cluster index fields.
// - 074 reads the T register chosen by jk; 075 writes it from source.
// - hold issue while the named scalar register is reserved.
// - shared ops hold on conflict or full buffer; mask read holds on full queue.
// - mask read waits at vector stage while mask busy or after element read.
// - T read holds after T write; T ops hold on 037 and variant 036 cases.
// - one-clock issue; results after 1, 15, 4 from vector issue, or 1 clocks.
// - test-and-set may issue 11 clocks after a semaphore write.
// - half-rate: mask read, shared writes align to system clock; locals wait globals.
package srt_pkg;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 9;
  localparam int I_MSB = 8;
  localparam int I_LSB = 6;
  localparam int J_MSB = 5;
  localparam int J_LSB = 3;
  localparam int K_MSB = 2;
  localparam int K_LSB = 0;
  localparam logic [6:0] OP_RD_SPECIAL = 7'h3a;
  localparam logic [6:0] OP_WR_SPECIAL = 7'h3b;
  localparam logic [6:0] OP_T_READ = 7'h3c;
  localparam logic [6:0] OP_T_WRITE = 7'h3d;
  localparam logic [5:0] JK_CLOCK = 6'h00;
  localparam logic [5:0] JK_SEM = 6'h02;
  localparam logic [2:0] K_SHARED = 3'h3;
  localparam logic [5:0] JK_MASK = 6'h00;
  localparam logic [5:0] JK_STATUS = 6'h01;
  localparam logic [5:0] JK_PERF_RD = 6'h09;
  localparam logic [5:0] JK_PERF_UP = 6'h11;
  localparam logic [5:0] JK_MAINT_CLR = 6'h19;
  localparam logic [5:0] JK_PERF_LO = 6'h31;
  localparam int SEM_LSB = 32;
  localparam int HALF = 32;
  localparam int PERF_CNT_LSB = 32;
  localparam int PERF_STAT_LSB = 48;
  localparam int PERF_UP_BIT_A = 22;
  localparam int PERF_UP_BIT_B = 38;
  localparam int PERF_SLICE_W = 16;
  localparam int PERF_W = 48;
  localparam logic [1:0] PERF_SLICES = 2'h3;
  localparam int SW_GROUPED = 63;
  localparam int SW_PSTATE = 57;
  localparam int SW_UME = 53;
  localparam int SW_CME = 52;
  localparam int SW_FPE = 51;
  localparam int SW_FIRQ = 50;
  localparam int SW_RIRQ = 49;
  localparam int SW_BIDIR = 48;
  localparam int SW_CPU_LSB = 40;
  localparam int SW_CL_LSB = 32;
  localparam logic [6:0] BLK_LEN_LIMIT = 7'h40;
  localparam int CLK_NS = 100;
  localparam int MAINT_STOP_NS = 1000;
  localparam int MAINT_STOP_CYC = MAINT_STOP_NS / CLK_NS;
  localparam logic [4:0] LAT_ONE = 5'h01;
  localparam logic [4:0] LAT_SHARED = 5'h0f;
  localparam logic [4:0] LAT_MASK = 5'h04;
  localparam logic [4:0] CNT_FIRE = 5'h02;
  localparam logic [4:0] SEM_TAS_WAIT = 5'h0b;
  localparam logic [7:0] MASK_BUSY_SET = 8'h07;
  localparam logic [7:0] MASK_BUSY_175 = 8'h06;
  localparam logic [7:0] MASK_BUSY_003 = 8'h04;
  localparam logic [7:0] ELEM_RD_DELAY = 8'h06;
endpackage : srt_pkg

// file: design/wall_counter.sv
`timescale 1ns/1ns
module wall_counter (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic step_i,
  input wire logic load_i,
  input wire logic [63:0] value_i,
  output logic [63:0] count_o
);
  logic [63:0] count_reg;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_reg <= '0;
    else if (load_i)
      count_reg <= value_i;
    else if (step_i)
      count_reg <= count_reg + 64'h1;
  end
  assign count_o = count_reg;
endmodule : wall_counter

// file: verif/test_special_register_transfer_unit.sv
`timescale 1ns/1ns
module test_special_register_transfer_unit;
  logic clk_i, resetn_i, half_rate_i, monitor_mode_i, issue_valid_i, si_reserved_i;
  logic shared_conflict_i, shared_buf_full_i, vq_full_i, global_pending_i, blk036_busy_i;
  logic t_target_written_i, blk037_busy_i, clock_load_i, mask_set_146_i, mask_set_175_i;
  logic mask_set_003_i, elem_read_issued_i, maint_set_i, issue_hold_o, issued_o;
  logic mask_half_sel_o, result_valid_o, tas_ok_o;
  logic [15:0] instr_i;
  logic [63:0] scalar_src_i, clock_load_val_i, mask_word, got, v1, result_o;
  logic [6:0] blk036_len_i, vector_length_i, flags;
  logic [31:0] mask_bus_i, perf_status_i, semaphore_bits_o;
  logic [7:0] maint_bits_i, maint_modes_o;
  logic [5:0] cluster_index_i;
  logic [4:0] cpu_index_i;
  logic [2:0] result_dest_o;
  int error_cnt = 0, check_count = 0, cyc = 0, t_iss, t1;
  special_register_transfer_unit u_special_register_transfer_unit (.clk_i(clk_i),
    .resetn_i(resetn_i), .half_rate_i(half_rate_i), .monitor_mode_i(monitor_mode_i),
    .issue_valid_i(issue_valid_i), .instr_i(instr_i), .scalar_src_i(scalar_src_i),
    .si_reserved_i(si_reserved_i), .shared_conflict_i(shared_conflict_i),
    .shared_buf_full_i(shared_buf_full_i), .vq_full_i(vq_full_i),
    .global_pending_i(global_pending_i), .blk036_busy_i(blk036_busy_i),
    .blk036_len_i(blk036_len_i), .t_target_written_i(t_target_written_i),
    .blk037_busy_i(blk037_busy_i), .clock_load_i(clock_load_i),
    .clock_load_val_i(clock_load_val_i), .vector_length_i(vector_length_i),
    .mask_set_146_i(mask_set_146_i), .mask_set_175_i(mask_set_175_i),
    .mask_set_003_i(mask_set_003_i), .elem_read_issued_i(elem_read_issued_i),
    .mask_bus_i(mask_bus_i), .perf_status_i(perf_status_i), .maint_set_i(maint_set_i),
    .maint_bits_i(maint_bits_i), .cluster_index_i(cluster_index_i),
    .cpu_index_i(cpu_index_i), .program_state_i(flags[6]),
    .uncorrected_mem_err_i(flags[5]), .corrected_mem_err_i(flags[4]),
    .float_err_flag_i(flags[3]), .float_irq_en_i(flags[2]), .range_irq_en_i(flags[1]),
    .bidir_mem_en_i(flags[0]), .issue_hold_o(issue_hold_o), .issued_o(issued_o),
    .mask_half_sel_o(mask_half_sel_o), .result_valid_o(result_valid_o),
    .result_dest_o(result_dest_o), .result_o(result_o), .tas_ok_o(tas_ok_o),
    .maint_modes_o(maint_modes_o), .semaphore_bits_o(semaphore_bits_o));
  vector_unit_model u_vector_unit_model (.half_sel_i(mask_half_sel_o), .mask_i(mask_word),
    .mask_bus_o(mask_bus_i));
  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] exp, input logic [63:0] act);
    check_count++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : chk
  function automatic logic [15:0] ins(input logic [6:0] op, input logic [2:0] i,
    input logic [5:0] jk);
    return {op, i, jk};
  endfunction : ins
  // status word as the processor should report it
  function automatic logic [63:0] sw(input logic mon);
    return {cluster_index_i != 6'h0, 5'h0, flags[6], 3'h0, flags[5:0], 3'h0,
      mon ? cpu_index_i : 5'h0, 2'h0, mon ? cluster_index_i : 6'h0, 32'hffffffff};
  endfunction : sw
  task automatic issue(input logic [15:0] op, input logic [63:0] src);
    int n;
    n = 0;
    @(negedge clk_i);
    issue_valid_i = 1'h1;
    instr_i = op;
    scalar_src_i = src;
    #1;
    while (issued_o !== 1'h1 && n < 50)
    begin
      @(negedge clk_i);
      #1;
      n++;
    end
    t_iss = cyc;
    @(negedge clk_i);
    issue_valid_i = 1'h0;
  endtask : issue
  task automatic rd(input logic [15:0] op, input int lat);
    int n;
    issue(op, 64'h0);
    n = 1;
    while (result_valid_o !== 1'h1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    got = result_o;
    if (lat > 0) chk(64'(lat), 64'(n));
  endtask : rd
  // offer an instruction under a hold; it must not be taken
  task automatic held(input logic [15:0] op);
    @(negedge clk_i);
    issue_valid_i = 1'h1;
    instr_i = op;
    #1;
    chk(64'h1, {63'h0, issue_hold_o});
    chk(64'h0, {63'h0, issued_o});
    @(negedge clk_i);
    issue_valid_i = 1'h0;
  endtask : held
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    {resetn_i, half_rate_i, issue_valid_i, si_reserved_i, shared_conflict_i} = 5'h0;
    {shared_buf_full_i, vq_full_i, global_pending_i, blk036_busy_i, blk037_busy_i} = 5'h0;
    {t_target_written_i, clock_load_i, mask_set_146_i, mask_set_175_i} = 4'h0;
    {mask_set_003_i, elem_read_issued_i, maint_set_i} = 3'h0;
    {instr_i, scalar_src_i, clock_load_val_i, blk036_len_i, vector_length_i} = 158'h0;
    {maint_bits_i, perf_status_i} = {8'h0, 32'h5a5ac3c3};
    {cluster_index_i, cpu_index_i, flags, monitor_mode_i} = {6'h2a, 5'h13, 7'h55, 1'h1};
    mask_word = 64'h13579bdf2468ace0;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'h1;
    chk(64'h1, {63'h0, tas_ok_o});
    chk(64'h0, {32'h0, semaphore_bits_o});
    rd(ins(srt_pkg::OP_RD_SPECIAL, 3'h1, srt_pkg::JK_CLOCK), 1);
    v1 = got;
    t1 = t_iss;
    rd(ins(srt_pkg::OP_RD_SPECIAL, 3'h1, srt_pkg::JK_CLOCK), 1);
    chk(64'(t_iss - t1), got - v1);
    $display("wall counter test done");
    issue(ins(srt_pkg::OP_WR_SPECIAL, 3'h2, srt_pkg::JK_SEM), 64'hdeadbeef12345678);
    chk(64'hdeadbeef, {32'h0, semaphore_bits_o});
    chk(64'h0, {63'h0, tas_ok_o});
    repeat (9) @(negedge clk_i);
    chk(64'h0, {63'h0, tas_ok_o});
    @(negedge clk_i);
    chk(64'h1, {63'h0, tas_ok_o});
    rd(ins(srt_pkg::OP_RD_SPECIAL, 3'h2, srt_pkg::JK_SEM), 15);
    chk(64'hdeadbeef00000000, got);
    issue({srt_pkg::OP_WR_SPECIAL, 3'h3, 3'h5, srt_pkg::K_SHARED}, 64'h0123456789abcdef);
    rd({srt_pkg::OP_RD_SPECIAL, 3'h3, 3'h5, srt_pkg::K_SHARED}, 15);
    chk(64'h0123456789abcdef, got);
    cluster_index_i = 6'h0;
    issue(ins(srt_pkg::OP_WR_SPECIAL, 3'h2, srt_pkg::JK_SEM), 64'hffffffffffffffff);
    chk(64'hdeadbeef, {32'h0, semaphore_bits_o});
    rd(ins(srt_pkg::OP_RD_SPECIAL, 3'h2, srt_pkg::JK_SEM), 15);
    chk(64'h0, got);
    rd({srt_pkg::OP_RD_SPECIAL, 3'h3, 3'h5, srt_pkg::K_SHARED}, 15);
    chk(64'h0, got);
    cluster_index_i = 6'h2a;
    $display("semaphore and shared test done");
    si_reserved_i = 1'h1;
    held(ins(srt_pkg::OP_RD_SPECIAL, 3'h2, srt_pkg::JK_SEM));
    si_reserved_i = 1'h0;
    shared_conflict_i = 1'h1;
    held({srt_pkg::OP_RD_SPECIAL, 3'h3, 3'h5, srt_pkg::K_SHARED});
    shared_conflict_i = 1'h0;
    vq_full_i = 1'h1;
    held(ins(srt_pkg::OP_WR_SPECIAL, 3'h4, srt_pkg::JK_MASK));
    vq_full_i = 1'h0;
    blk037_busy_i = 1'h1;
    held(ins(srt_pkg::OP_T_READ, 3'h4, 6'h15));
    blk037_busy_i = 1'h0;
    $display("hold test done");
    issue(ins(srt_pkg::OP_T_WRITE, 3'h6, 6'h15), 64'hfeedc0de55aa33cc);
    rd(ins(srt_pkg::OP_T_READ, 3'h4, 6'h15), 1);
    chk(64'hfeedc0de55aa33cc, got);
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h2, srt_pkg::JK_MASK), 0);
    chk(mask_word, got);
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h1, srt_pkg::JK_STATUS), 1);
    chk(sw(1'h1), got);
    monitor_mode_i = 1'h0;
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h1, srt_pkg::JK_STATUS), 1);
    chk(sw(1'h0), got);
    monitor_mode_i = 1'h1;
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h5, srt_pkg::JK_PERF_UP), 1);
    chk({32'h5a5ac3c3, 32'h0}, got);
    repeat (8) @(negedge clk_i);
    maint_bits_i = 8'ha5;
    maint_set_i = 1'h1;
    @(negedge clk_i);
    maint_set_i = 1'h0;
    chk(64'ha5, {56'h0, maint_modes_o});
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h5, srt_pkg::JK_MAINT_CLR), 1);
    chk(64'h0, {56'h0, maint_modes_o});
    chk({32'h5a5ac3c3, 32'h0}, {got[63:32], 32'h0});
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h5, srt_pkg::JK_PERF_RD), 1);
    rd(ins(srt_pkg::OP_WR_SPECIAL, 3'h5, srt_pkg::JK_PERF_RD), 1);
    chk({16'hc3c3, 16'h0040, 32'h0}, got);
    $display("transfer and status test done");
    finish_test();
  end
endmodule : test_special_register_transfer_unit

// file: verif/vector_unit_model.sv
`timescale 1ns/1ns
module vector_unit_model (
  input wire logic half_sel_i,
  input wire logic [63:0] mask_i,
  output logic [31:0] mask_bus_o
);
  // only the half asked for is put on the 32-bit bus
  always_comb mask_bus_o = half_sel_i ? mask_i[63:32] : mask_i[31:0];
endmodule : vector_unit_model
